// >>> rtl/sac_regs.sv
// module: advanced control register slice with link change interrupt
// Overview of operation
// - Port three serves its queues by strict priority when all split select bits and the global selector are 0, and by 8:4:2:1 or 2:1 weights when the bits are 1.
// - The lowest-queue split select bit resets to 1 and its seven reserved low bits read as the value 1.
// - An eight-bit enable register, reset to zero, gates each link change status bit in the same position.
// - Status bit 7 sets on a link change of copper port one or two and holds until written with 1.
// - Status bit 2 sets on a link change of port three on its media-independent interface and clears on a write of 1.
// - Status bit 1 sets on a copper link change of port two; writing 1 clears it and writing 0 leaves it.
// - Status bit 0 sets on a link change of port one on either its copper or media-independent interface and clears on a write of 1.
// - With the limit enabled the block asks to invalidate flow control after 160 ms of continuous flow control; it resets disabled.
// - One bit per port one and two selects the fiber signal threshold, 1 for 2.0V and 0 for 1.2V, both reset to 0.
// - Bit 6 of the regulator register disables the internal 1.8V regulator when 1 and resets to 0.
// - Bit 5 inserts port one's default VLAN ID into untagged frames from port one leaving port two.
// - Bit 4 inserts port one's default VLAN ID into untagged frames from port one leaving port three.
module sac_regs
  import sac_pkg::*;
#(
  parameter int PAUSE_CYCLES = sac_pkg::SAC_PAUSE_LIMIT_CYCLES
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire logic [7:0]         i_reg_wdata,
  input  wire logic               i_reg_rd,
  output logic      [7:0]         o_reg_rdata,
  input  wire logic               i_port_one_link,
  input  wire logic               i_port_one_mii_link,
  input  wire logic               i_port_two_link,
  input  wire logic               i_port_three_mii_link,
  input  wire logic [2:0]         i_port_three_upper_split_sel,
  input  wire logic               i_global_sched_sel,
  input  wire logic               i_port_three_four_queues,
  input  wire logic               i_flow_ctrl_active,
  output logic                    o_link_irq_pin_n,
  output sac_pkg::sac_sched_t     o_port_three_sched,
  output logic                    o_pause_invalidate_req,
  output logic                    o_port_one_fiber_thr_high,
  output logic                    o_port_two_fiber_thr_high,
  output logic                    o_ldo_disable,
  output logic                    o_insert_vid_one_to_two,
  output logic                    o_insert_vid_one_to_three
);
  import sac_pkg::*;

  // ==========================================================
  // storage
  logic       split_sel_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] lc_stat_reg;
  logic [7:0] lc_stat_next;
  logic [7:0] pause_reg;

  // ==========================================================
  // address decode
  wire wr_split = i_reg_wr && (i_reg_addr == SAC_ADDR_SPLIT);
  wire wr_irq   = i_reg_wr && (i_reg_addr == SAC_ADDR_IRQ_EN);
  wire wr_stat  = i_reg_wr && (i_reg_addr == SAC_ADDR_LC_STAT);
  wire wr_pause = i_reg_wr && (i_reg_addr == SAC_ADDR_PAUSE);
  wire wr_fiber = i_reg_wr && (i_reg_addr == SAC_ADDR_FIBER);
  wire wr_ldo   = i_reg_wr && (i_reg_addr == SAC_ADDR_LDO);
  wire wr_vlan  = i_reg_wr && (i_reg_addr == SAC_ADDR_VLAN);

  // ==========================================================
  // link change events
  logic [3:0] link_chg;

  sac_link_edge #(
    .W (4)
  ) u_link_edge (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  ({i_port_three_mii_link, i_port_two_link, i_port_one_mii_link, i_port_one_link}),
    .o_change (link_chg)
  );

  wire p1_chg = link_chg[0] | link_chg[1];
  wire p2_chg = link_chg[2];
  wire p3_chg = link_chg[3];

  logic [7:0] set_mask;
  always_comb
  begin
    set_mask                 = 8'h00;
    set_mask[SAC_LC_P12_BIT] = link_chg[0] | p2_chg;
    set_mask[SAC_LC_P3_BIT]  = p3_chg;
    set_mask[SAC_LC_P2_BIT]  = p2_chg;
    set_mask[SAC_LC_P1_BIT]  = p1_chg;
  end

  // ==========================================================
  // status next value
  // set beats a same-cycle write of one so no change is lost;
  // reserved bits just store what is written
  wire [7:0] clr_mask  = wr_stat ? i_reg_wdata : 8'h00;
  wire [7:0] evt_mask  = 8'h87;
  always_comb
  begin
    lc_stat_next = ((lc_stat_reg & ~clr_mask) | set_mask) & evt_mask;
    lc_stat_next[SAC_LC_RSVD_HI:SAC_LC_RSVD_LO] = wr_stat
      ? i_reg_wdata[SAC_LC_RSVD_HI:SAC_LC_RSVD_LO]
      : lc_stat_reg[SAC_LC_RSVD_HI:SAC_LC_RSVD_LO];
  end

  wire irq_active = |(lc_stat_reg & irq_en_reg);

  // ==========================================================
  // port three scheduling decode
  wire [3:0]  split_all = {i_port_three_upper_split_sel, split_sel_reg};
  sac_sched_t sched_next;
  always_comb
  begin
    if ((split_all == 4'h0) && !i_global_sched_sel)
      sched_next = SAC_SCHED_STRICT;
    else if (split_all == 4'hF)
      sched_next = i_port_three_four_queues ? SAC_SCHED_W8421 : SAC_SCHED_W21;
    else
      sched_next = SAC_SCHED_MIXED;
  end

  // ==========================================================
  // read mux
  // reserved fields read back their fixed values, except status bits 6:3 and pause bits 7:1, which read back what was last written
  logic [7:0] rd_mux;
  always_comb
  begin
    case (i_reg_addr)
      SAC_ADDR_SPLIT:   rd_mux = {split_sel_reg, SAC_SPLIT_RSVD};
      SAC_ADDR_IRQ_EN:  rd_mux = irq_en_reg;
      SAC_ADDR_LC_STAT: rd_mux = lc_stat_reg;
      SAC_ADDR_PAUSE:   rd_mux = pause_reg;
      SAC_ADDR_FIBER:   rd_mux = {o_port_two_fiber_thr_high, o_port_one_fiber_thr_high, 6'h00};
      SAC_ADDR_LDO:     rd_mux = {1'b0, o_ldo_disable, 6'h00};
      SAC_ADDR_VLAN:    rd_mux = {2'h0, o_insert_vid_one_to_two, o_insert_vid_one_to_three, 4'h0};
      default:          rd_mux = SAC_UNMAPPED_DATA;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      split_sel_reg <= SAC_SPLIT_SEL_RST;
      irq_en_reg    <= SAC_IRQ_EN_RST;
      lc_stat_reg   <= SAC_LC_STAT_RST;
      pause_reg     <= SAC_PAUSE_RST;
    end
    else
    begin
      lc_stat_reg <= lc_stat_next;
      if (wr_split)
        split_sel_reg <= i_reg_wdata[SAC_SPLIT_SEL_BIT];
      if (wr_irq)
        irq_en_reg <= i_reg_wdata;
      if (wr_pause)
        pause_reg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_port_one_fiber_thr_high <= SAC_FIBER_RST[0];
      o_port_two_fiber_thr_high <= SAC_FIBER_RST[1];
      o_ldo_disable             <= SAC_LDO_RST;
      o_insert_vid_one_to_two   <= SAC_VLAN_RST[1];
      o_insert_vid_one_to_three <= SAC_VLAN_RST[0];
    end
    else
    begin
      if (wr_fiber)
      begin
        o_port_one_fiber_thr_high <= i_reg_wdata[SAC_FIBER_P1_BIT];
        o_port_two_fiber_thr_high <= i_reg_wdata[SAC_FIBER_P2_BIT];
      end
      if (wr_ldo)
        o_ldo_disable <= i_reg_wdata[SAC_LDO_DIS_BIT];
      if (wr_vlan)
      begin
        o_insert_vid_one_to_two   <= i_reg_wdata[SAC_VLAN_P1P2_BIT];
        o_insert_vid_one_to_three <= i_reg_wdata[SAC_VLAN_P1P3_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata        <= 8'h00;
      o_link_irq_pin_n   <= 1'b1;
      o_port_three_sched <= SAC_SCHED_MIXED;
    end
    else
    begin
      if (i_reg_rd)
        o_reg_rdata <= rd_mux;
      o_link_irq_pin_n   <= !irq_active;
      o_port_three_sched <= sched_next;
    end
  end

  // ==========================================================
  // flow control limit
  sac_pause_timer #(
    .CYCLES (PAUSE_CYCLES)
  ) u_pause_timer (
    .i_clk            (i_clk),
    .i_resetn         (i_resetn),
    .i_enable         (pause_reg[SAC_PAUSE_EN_BIT]),
    .i_flow_active    (i_flow_ctrl_active),
    .o_invalidate_req (o_pause_invalidate_req)
  );

  // ==========================================================
  // checks
  property p_p12_sets;
    @(posedge i_clk) disable iff (!i_resetn)
      (link_chg[0] || link_chg[2]) |=> lc_stat_reg[SAC_LC_P12_BIT];
  endproperty
  a_p12_sets: assert property (p_p12_sets)
    else $error("copper link change did not set status bit 7");

  property p_p3_sets;
    @(posedge i_clk) disable iff (!i_resetn)
      link_chg[3] |=> lc_stat_reg[SAC_LC_P3_BIT];
  endproperty
  a_p3_sets: assert property (p_p3_sets)
    else $error("port three link change did not set status bit 2");

  property p_zero_write_keeps;
    @(posedge i_clk) disable iff (!i_resetn)
      (lc_stat_reg[SAC_LC_P2_BIT] && wr_stat && !i_reg_wdata[SAC_LC_P2_BIT])
        |=> lc_stat_reg[SAC_LC_P2_BIT];
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("writing zero cleared status bit 1");

  property p_one_write_clears;
    @(posedge i_clk) disable iff (!i_resetn)
      (wr_stat && i_reg_wdata[SAC_LC_P1_BIT] && !p1_chg) |=> !lc_stat_reg[SAC_LC_P1_BIT];
  endproperty
  a_one_write_clears: assert property (p_one_write_clears)
    else $error("writing one did not clear status bit 0");

  property p_irq_follows;
    @(posedge i_clk) disable iff (!i_resetn)
      ##1 (o_link_irq_pin_n == !$past(|(lc_stat_reg & irq_en_reg)));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt pin disagrees with enabled status");

  property p_enable_write;
    @(posedge i_clk) disable iff (!i_resetn)
      wr_irq |=> (irq_en_reg == $past(i_reg_wdata));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("interrupt enable register did not take the write");

  property p_split_read;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_reg_rd && i_reg_addr == SAC_ADDR_SPLIT) |=> (o_reg_rdata[6:0] == SAC_SPLIT_RSVD);
  endproperty
  a_split_read: assert property (p_split_read)
    else $error("split reserved bits did not read as one");

  property p_weighted;
    @(posedge i_clk) disable iff (!i_resetn)
      (split_all == 4'hF && i_port_three_four_queues) |=> (o_port_three_sched == SAC_SCHED_W8421);
  endproperty
  a_weighted: assert property (p_weighted)
    else $error("all split bits set but 8:4:2:1 not selected");

  property p_ldo_write;
    @(posedge i_clk) disable iff (!i_resetn)
      wr_ldo |=> (o_ldo_disable == $past(i_reg_wdata[SAC_LDO_DIS_BIT]));
  endproperty
  a_ldo_write: assert property (p_ldo_write)
    else $error("regulator disable did not follow bit 6");

  property p_vlan_write;
    @(posedge i_clk) disable iff (!i_resetn)
      wr_vlan |=> (o_insert_vid_one_to_two == $past(i_reg_wdata[SAC_VLAN_P1P2_BIT]))
               && (o_insert_vid_one_to_three == $past(i_reg_wdata[SAC_VLAN_P1P3_BIT]));
  endproperty
  a_vlan_write: assert property (p_vlan_write)
    else $error("vlan insert controls did not take the write");

  property p_fiber_write;
    @(posedge i_clk) disable iff (!i_resetn)
      wr_fiber |=> (o_port_one_fiber_thr_high == $past(i_reg_wdata[SAC_FIBER_P1_BIT]))
                && (o_port_two_fiber_thr_high == $past(i_reg_wdata[SAC_FIBER_P2_BIT]));
  endproperty
  a_fiber_write: assert property (p_fiber_write)
    else $error("fiber threshold selects did not take the write");

  property p_split_write;
    @(posedge i_clk) disable iff (!i_resetn)
      wr_split |=> (split_sel_reg == $past(i_reg_wdata[SAC_SPLIT_SEL_BIT]));
  endproperty
  a_split_write: assert property (p_split_write)
    else $error("split select bit did not take the write");

endmodule : sac_regs

// >>> rtl/sac_pkg.sv
// package: offsets, fields, resets and timing for the advanced control slice
package sac_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] SAC_ADDR_SPLIT   = 8'hBA;
  localparam logic [7:0] SAC_ADDR_IRQ_EN  = 8'hBB;
  localparam logic [7:0] SAC_ADDR_LC_STAT = 8'hBC;
  localparam logic [7:0] SAC_ADDR_PAUSE   = 8'hBD;
  localparam logic [7:0] SAC_ADDR_FIBER   = 8'hC0;
  localparam logic [7:0] SAC_ADDR_LDO     = 8'hC1;
  localparam logic [7:0] SAC_ADDR_VLAN    = 8'hC2;

  // ==========================================================
  // field positions
  localparam int SAC_SPLIT_SEL_BIT  = 7;
  localparam int SAC_LC_P12_BIT     = 7;
  localparam int SAC_LC_RSVD_HI     = 6;
  localparam int SAC_LC_RSVD_LO     = 3;
  localparam int SAC_LC_P3_BIT      = 2;
  localparam int SAC_LC_P2_BIT      = 1;
  localparam int SAC_LC_P1_BIT      = 0;
  localparam int SAC_PAUSE_EN_BIT   = 0;
  localparam int SAC_FIBER_P2_BIT   = 7;
  localparam int SAC_FIBER_P1_BIT   = 6;
  localparam int SAC_LDO_DIS_BIT    = 6;
  localparam int SAC_VLAN_P1P2_BIT  = 5;
  localparam int SAC_VLAN_P1P3_BIT  = 4;

  // ==========================================================
  // reset values
  localparam logic       SAC_SPLIT_SEL_RST = 1'b1;
  localparam logic [6:0] SAC_SPLIT_RSVD    = 7'h01;
  localparam logic [7:0] SAC_IRQ_EN_RST    = 8'h00;
  localparam logic [7:0] SAC_LC_STAT_RST   = 8'h00;
  localparam logic [7:0] SAC_PAUSE_RST     = 8'h00;
  localparam logic [1:0] SAC_FIBER_RST     = 2'h0;
  localparam logic       SAC_LDO_RST       = 1'b0;
  localparam logic [1:0] SAC_VLAN_RST      = 2'h0;
  localparam logic [7:0] SAC_UNMAPPED_DATA = 8'h00;

  // ==========================================================
  // timing
  localparam int SAC_CLK_HZ             = 25_000_000;
  localparam int SAC_PAUSE_LIMIT_MS     = 160;
  localparam int SAC_PAUSE_LIMIT_CYCLES = SAC_PAUSE_LIMIT_MS * (SAC_CLK_HZ / 1000);

  // ==========================================================
  // port three egress scheduling modes
  typedef enum logic [1:0]
  {
    SAC_SCHED_STRICT = 2'b00,
    SAC_SCHED_W8421  = 2'b01,
    SAC_SCHED_W21    = 2'b10,
    SAC_SCHED_MIXED  = 2'b11
  } sac_sched_t;

endpackage : sac_pkg

// >>> rtl/sac_link_edge.sv
// module: link level synchroniser and change detector, one lane per link
module sac_link_edge #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_level,
  output logic      [W-1:0] o_change
);
  import sac_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // ==========================================================
  // per-lane sync and edge
  // a link already up at reset shows as one change after release
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_lane
      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
          o_change[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= i_level[g];
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= sync_reg[g];
          o_change[g] <= sync_reg[g] ^ prev_reg[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // checks
  property p_change_follows_edge;
    @(posedge i_clk) disable iff (!i_resetn)
      (sync_reg != prev_reg) |=> (o_change == $past(sync_reg ^ prev_reg));
  endproperty
  a_change_follows_edge: assert property (p_change_follows_edge)
    else $error("link change pulse does not match the synchronised edge");

endmodule : sac_link_edge

// >>> rtl/sac_pause_timer.sv
// module: continuous flow control limit timer
module sac_pause_timer #(
  parameter int CYCLES = 4_000_000
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_enable,
  input  wire logic i_flow_active,
  output logic      o_invalidate_req
);
  import sac_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;
  wire           running = i_enable && i_flow_active;
  wire           at_last = (count_reg == LAST);

  // ==========================================================
  // counter
  // any break in flow control restarts the full wait
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count_reg        <= '0;
      o_invalidate_req <= 1'b0;
    end
    else if (!running)
    begin
      count_reg        <= '0;
      o_invalidate_req <= 1'b0;
    end
    else if (at_last)
    begin
      o_invalidate_req <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + CW'(1);
    end
  end

  // ==========================================================
  // checks
  property p_no_req_when_off;
    @(posedge i_clk) disable iff (!i_resetn)
      !i_enable |=> !o_invalidate_req;
  endproperty
  a_no_req_when_off: assert property (p_no_req_when_off)
    else $error("flow control invalidate requested while limit disabled");

  property p_req_after_full_wait;
    @(posedge i_clk) disable iff (!i_resetn)
      $rose(o_invalidate_req) |-> ($past(count_reg) == LAST) && $past(running);
  endproperty
  a_req_after_full_wait: assert property (p_req_after_full_wait)
    else $error("invalidate request came before the full wait");

endmodule : sac_pause_timer

// >>> testbench/sac_host_model.sv
// host processor model driving the parallel register port
module sac_host_model (
  input  wire logic       i_clk,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;

  // idle cycles after each access, raised to model a slow host
  int gap = 0;

  // ==========================================================
  // idle bus
  initial
  begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'hA5;
    o_wdata = 8'h5A;
  end

  // ==========================================================
  // reserved fields go back at their reset values, except pause bits 7:1, which go back as given
  function automatic logic [7:0] keep_rsvd(input logic [7:0] a, input logic [7:0] d);
    case (a)
      SAC_ADDR_SPLIT:   keep_rsvd = {d[7], 7'h01};
      SAC_ADDR_LC_STAT: keep_rsvd = d & 8'h87;
      SAC_ADDR_FIBER:   keep_rsvd = d & 8'hC0;
      SAC_ADDR_LDO:     keep_rsvd = d & 8'h40;
      SAC_ADDR_VLAN:    keep_rsvd = d & 8'h30;
      default:          keep_rsvd = d;
    endcase
  endfunction : keep_rsvd

  // ==========================================================
  // one access; keep = 0 only where a scenario abuses reserved bits
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w, input logic keep);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = keep ? keep_rsvd(a, d) : d;
    o_wr    = w;
    o_rd    = ~w;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    // released lines wander so stale values never look valid
    o_addr  = 8'($urandom);
    o_wdata = 8'($urandom);
    repeat (gap) @(negedge i_clk);
  endtask : access

endmodule : sac_host_model

// >>> testbench/sac_regs_test.sv
// testbench: self-checking bench for the advanced control register slice
module sac_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sac_pkg::*;

  // ==========================================================
  // signals and tables
  localparam int PC = 8;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] addr, wdata, rdata, v;
  logic       wr, rd, irq_n, preq, f1, f2, ldo, v12, v13;
  logic       l1 = 1'b0, l1m = 1'b0, l2 = 1'b0, l3m = 1'b0;
  logic [2:0] up = 3'h0;
  logic       gsel = 1'b0, fourq = 1'b0, flow = 1'b0, rd_dly = 1'b0;
  sac_sched_t sched;
  int         mismatches = 0, total_checks = 0, cycles = 0;
  logic [7:0] exp_q[$];
  logic [7:0] wv[6];
  logic [7:0] ra[6] = '{SAC_ADDR_SPLIT, SAC_ADDR_IRQ_EN, SAC_ADDR_PAUSE, SAC_ADDR_FIBER, SAC_ADDR_LDO, SAC_ADDR_VLAN};
  logic [7:0] rm[6] = '{8'h80, 8'hFF, 8'hFF, 8'hC0, 8'h40, 8'h30};
  logic [7:0] rr[6] = '{8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic       sp[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic [2:0] su[4] = '{3'h0, 3'h7, 3'h7, 3'h3};
  logic       sq[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  sac_sched_t se[4] = '{SAC_SCHED_STRICT, SAC_SCHED_W8421, SAC_SCHED_W21, SAC_SCHED_MIXED};
  logic [7:0] ls[4] = '{8'h81, 8'h01, 8'h82, 8'h04};
  // last entry leaves bit 2 disabled so its event must not pull the pin
  logic [7:0] le[4] = '{8'h87, 8'h87, 8'h87, 8'h83};

  always #20 clk = ~clk;

  sac_host_model sac_host_model_i (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));

  sac_regs #(.PAUSE_CYCLES(PC)) sac_regs_i (
    .i_clk(clk), .i_resetn(resetn), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_port_one_link(l1), .i_port_one_mii_link(l1m),
    .i_port_two_link(l2), .i_port_three_mii_link(l3m), .i_port_three_upper_split_sel(up),
    .i_global_sched_sel(gsel), .i_port_three_four_queues(fourq), .i_flow_ctrl_active(flow),
    .o_link_irq_pin_n(irq_n), .o_port_three_sched(sched), .o_pause_invalidate_req(preq),
    .o_port_one_fiber_thr_high(f1), .o_port_two_fiber_thr_high(f2), .o_ldo_disable(ldo),
    .o_insert_vid_one_to_two(v12), .o_insert_vid_one_to_three(v13));

  // ==========================================================
  // reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ==========================================================
  // read data monitor: one edge after each taken read
  always @(posedge clk) rd_dly <= rd;
  always @(negedge clk)
  begin
    if (rd_dly === 1'b1)
    begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
  end

  // ==========================================================
  // bus helpers
  task automatic wr8(input logic [7:0] a, input logic [7:0] d, input logic keep = 1'b1);
    sac_host_model_i.access(a, d, 1'b1, keep);
  endtask : wr8

  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sac_host_model_i.access(a, 8'h00, 1'b0, 1'b1);
  endtask : rd8

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(13));
    wait_cyc(4);
    chk("irq_n", 8'h01, {7'h0, irq_n});
    resetn = 1'b1;
    wait_cyc(2);
    chk("sched", 8'h03, {6'h0, sched});
    for (int k = 0; k < 6; k++)
    begin
      rd8(ra[k], rr[k]);
    end
    rd8(SAC_ADDR_LC_STAT, 8'h00);
    wr8(8'hBE, 8'hFF);
    rd8(8'hBE, 8'h00);
    // random pass keeps reserved bits, second pass tries to break them
    for (int it = 0; it < 2; it++)
    begin
      for (int k = 0; k < 6; k++)
      begin
        v = (it != 0) ? 8'hFF : 8'($urandom);
        wv[k] = v;
        wr8(ra[k], v, it == 0);
        rd8(ra[k], (v & rm[k]) | (rr[k] & ~rm[k]));
      end
      chk("thr", {6'h0, wv[3][7:6]}, {6'h0, f2, f1});
      chk("ldo", {7'h0, wv[4][6]}, {7'h0, ldo});
      chk("vid", {6'h0, wv[5][5:4]}, {6'h0, v12, v13});
    end
    for (int k = 0; k < 4; k++)
    begin
      wr8(SAC_ADDR_SPLIT, {sp[k], 7'h01});
      up = su[k];
      fourq = sq[k];
      gsel = k[0];
      wait_cyc(2);
      chk("sched", {6'h0, se[k]}, {6'h0, sched});
    end
    sac_host_model_i.gap = 2;
    for (int k = 0; k < 4; k++)
    begin
      wr8(SAC_ADDR_IRQ_EN, le[k]);
      wr8(SAC_ADDR_LC_STAT, 8'hFF);
      case (k)
        0: l1 = ~l1;
        1: l1m = ~l1m;
        2: l2 = ~l2;
        default: l3m = ~l3m;
      endcase
      wait_cyc(8);
      chk("irq_n", {7'h0, (ls[k] & le[k]) == 8'h00}, {7'h0, irq_n});
      rd8(SAC_ADDR_LC_STAT, ls[k]);
      wr8(SAC_ADDR_LC_STAT, ls[k] & 8'h80);
      rd8(SAC_ADDR_LC_STAT, ls[k] & 8'h7F);
      wr8(SAC_ADDR_LC_STAT, ls[k]);
      rd8(SAC_ADDR_LC_STAT, 8'h00);
      chk("irq_n", 8'h01, {7'h0, irq_n});
    end
    sac_host_model_i.gap = 0;
    wr8(SAC_ADDR_PAUSE, 8'h01);
    flow = 1'b1;
    wait_cyc(PC - 1);
    chk("pause", 8'h00, {7'h0, preq});
    wait_cyc(1);
    chk("pause", 8'h01, {7'h0, preq});
    flow = 1'b0;
    wait_cyc(1);
    chk("pause", 8'h00, {7'h0, preq});
    wr8(SAC_ADDR_PAUSE, 8'h00);
    flow = 1'b1;
    wait_cyc(2 * PC);
    chk("pause", 8'h00, {7'h0, preq});
    // second reset while an enabled status bit holds the pin low
    l2 = ~l2;
    wait_cyc(8);
    chk("irq_n", 8'h00, {7'h0, irq_n});
    resetn = 1'b0;
    wait_cyc(2);
    chk("irq_n", 8'h01, {7'h0, irq_n});
    resetn = 1'b1;
    rd8(SAC_ADDR_IRQ_EN, 8'h00);
    rd8(SAC_ADDR_SPLIT, 8'h81);
    wait_cyc(2);
    finish_test();
  end

endmodule : sac_regs_test
